// ===== rtl/ncb_pkg.sv
// Package for the network controller register bank: fields, timing, carriers
// Overview of operation
// - Reset clears main register but sets stop; reads change nothing.
// - Error summary bit 15 is read-only OR of four error flags.
// - Babble flag sets after 1519 bytes sent in one transmission.
// - Seven event flags clear on written one, keep on zero, clear on stop.
// - Heartbeat flag sets if collision absent 2 us after own transmission.
// - Missed flag sets on packet lost for lack of buffer, not in loopback.
// - Memory error after 25.6 us without ready; receiver, transmitter off.
// - Receive or transmit flag sets on last descriptor update or failure.
// - Init-done flag sets once the init block has been read and stored.
// - Interrupt pending is read-only OR of six flags, heartbeat excluded.
// - Request when pending and enable set; enable writable, stop clears it.
// - Receiver on: set by start after init if enabled; error, stop clear.
// - Transmitter on like receiver on; also cleared by descriptor errors.
// - Transmit demand hastens poll; cleared when recognized or by stop.
// - Stop halts and resets all but select and pointers, clears other bits, holds until start/init.
// - Stop written with start and initialize: only stop takes effect.
// - Start enables operation, initialize reads block; either clears stop.
// - Pointer registers form a 24-bit byte address, low word and high byte.
// - Auxiliary registers reachable only while stopped; select 01, 10, 11.
// - Config: byte swap, strobe polarity, byte mask; writable, stop clears.
// - While running, auxiliary reads return undefined data; writes ignored.
// - Select field resets to zero; data port accesses never alter it.
package ncb_pkg;

  // Register select codes
  localparam logic [1:0] SEL_MAIN = 2'h0;
  localparam logic [1:0] SEL_ADDR_LOW = 2'h1;
  localparam logic [1:0] SEL_ADDR_HIGH = 2'h2;
  localparam logic [1:0] SEL_CONFIG = 2'h3;

  // Main register bit positions
  localparam int BIT_ERR = 15;
  localparam int BIT_BABBLE = 14;
  localparam int BIT_HEARTBEAT = 13;
  localparam int BIT_MISSED = 12;
  localparam int BIT_MEMERR = 11;
  localparam int BIT_RECEIVE = 10;
  localparam int BIT_TRANSMIT = 9;
  localparam int BIT_INITDONE = 8;
  localparam int BIT_PENDING = 7;
  localparam int BIT_INT_ENABLE = 6;
  localparam int BIT_RX_ON = 5;
  localparam int BIT_TX_ON = 4;
  localparam int BIT_TX_DEMAND = 3;
  localparam int BIT_STOP = 2;
  localparam int BIT_START = 1;
  localparam int BIT_INIT = 0;

  // Config register bit positions
  localparam int BIT_BYTE_SWAP = 2;
  localparam int BIT_STROBE_POL = 1;
  localparam int BIT_BYTE_MASK = 0;

  // Sticky flag indices inside the flag vector
  localparam int FLAG_COUNT = 7;
  localparam int FI_BABBLE = 0;
  localparam int FI_HEARTBEAT = 1;
  localparam int FI_MISSED = 2;
  localparam int FI_MEMERR = 3;
  localparam int FI_RECEIVE = 4;
  localparam int FI_TRANSMIT = 5;
  localparam int FI_INITDONE = 6;

  // Timing at 100 MHz
  localparam int CLK_PERIOD_PS = 10000;
  localparam int HEARTBEAT_WINDOW_PS = 2000000;   // 2 us
  localparam int DMA_TIMEOUT_PS = 25600000;       // 25.6 us
  localparam int HEARTBEAT_CYCLES = HEARTBEAT_WINDOW_PS / CLK_PERIOD_PS;
  localparam int DMA_TIMEOUT_CYCLES = DMA_TIMEOUT_PS / CLK_PERIOD_PS;
  localparam logic [7:0] HB_LAST = 8'(HEARTBEAT_CYCLES - 1);
  localparam logic [11:0] DMA_LAST = 12'(DMA_TIMEOUT_CYCLES - 1);
  localparam logic [10:0] BABBLE_BYTES = 11'h5EF;  // 1519

  // Reset values
  localparam logic [15:0] MAIN_RESET = 16'h0004;
  localparam logic [1:0] SEL_RESET = 2'h0;

  // Events from the controller core, all same-clock pulses or levels
  typedef struct packed {
    logic tx_byte;         // One data byte sent in current transmission
    logic tx_begin;        // Start of a transmission
    logic tx_end;          // Own transmission completed
    logic rx_missed;       // Packet lost, no receive buffer owned
    logic rx_desc_done;    // Last receive descriptor updated
    logic rx_fail;         // Reception stopped on failure
    logic tx_desc_done;    // Last transmit descriptor updated
    logic tx_fail;         // Transmission stopped on failure
    logic tx_desc_error;   // Underflow, buffer or retry error in descriptor
    logic init_complete;   // Init block read and parameters stored
    logic demand_seen;     // Core recognized the transmit demand
    logic dma_busy;        // A DMA memory cycle is in progress
    logic dma_ready;       // Memory ready response
  } ncb_evt_t;

  // Mode bits taken from the stored init block
  typedef struct packed {
    logic receiver_disable;
    logic transmitter_disable;
    logic internal_loopback;
  } ncb_mode_t;

  // Control outputs to the controller core
  typedef struct packed {
    logic        stop;
    logic        start_operation;
    logic        init_req;
    logic        receiver_on;
    logic        transmitter_on;
    logic        transmit_demand;
    logic [23:0] init_block_pointer;
    logic        byte_swap;
    logic        strobe_polarity;
    logic        byte_mask_config;
  } ncb_ctrl_t;

endpackage

// ===== rtl/ncb_flag_cell.sv
// Sticky event flag with write-one-to-clear and a stop clear
`timescale 1ns/1ns
module ncb_flag_cell
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);

  logic flag_ff;
  logic nxt_flag;

  // A set in the clear cycle wins so no event is lost; stop wins over all
  always_comb
  begin
    nxt_flag = set_i | (flag_ff & ~clr_i);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_ff <= 1'b0;
    else
      flag_ff <= nxt_flag;
  end

  assign flag_o = flag_ff;

endmodule

// ===== rtl/ncb_csr_bank.sv
// Network controller register bank with indexed select and data ports
`timescale 1ns/1ns
module ncb_csr_bank
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               host_port_sel_i,
  input  wire logic               host_wr_i,
  input  wire logic               host_rd_i,
  input  wire logic [15:0]        host_wdata_i,
  output logic      [15:0]        host_rdata_o,
  input  wire ncb_pkg::ncb_evt_t  evt_i,
  input  wire ncb_pkg::ncb_mode_t mode_i,
  input  wire logic               collision_i,
  output ncb_pkg::ncb_ctrl_t      ctrl_o,
  output logic                    irq_o
);

  // Port decode: select 0 is the data window, 1 the select port
  logic data_wr;
  logic sel_wr;
  logic main_wr;
  logic aux_wr;
  logic stop_req;
  logic clear_all;
  logic [ncb_pkg::FLAG_COUNT-1:0] flag_set;
  logic [ncb_pkg::FLAG_COUNT-1:0] flag_clr;
  logic [ncb_pkg::FLAG_COUNT-1:0] flags;

  logic [1:0]  sel_ff;
  logic [1:0]  nxt_sel;
  logic        stop_ff;
  logic        nxt_stop;
  logic        start_ff;
  logic        nxt_start;
  logic        init_ff;
  logic        nxt_init;
  logic        interrupt_enable_ff;
  logic        nxt_interrupt_enable;
  logic        receiver_on_ff;
  logic        nxt_receiver_on;
  logic        transmitter_on_ff;
  logic        nxt_transmitter_on;
  logic        transmit_demand_ff;
  logic        nxt_transmit_demand;
  logic        inited_ff;
  logic        nxt_inited;
  logic [15:0] addr_low_ff;
  logic [15:0] nxt_addr_low;
  logic [7:0]  addr_high_ff;
  logic [7:0]  nxt_addr_high;
  logic [2:0]  cfg_ff;
  logic [2:0]  nxt_cfg;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;

  logic        col_meta_ff;
  logic        col_sync_ff;
  logic [10:0] byte_cnt_ff;
  logic [10:0] nxt_byte_cnt;
  logic        hb_wait_ff;
  logic        nxt_hb_wait;
  logic [7:0]  hb_cnt_ff;
  logic [7:0]  nxt_hb_cnt;
  logic [11:0] dma_cnt_ff;
  logic [11:0] nxt_dma_cnt;
  logic        babble_hit;
  logic        hb_miss;
  logic        dma_timeout;
  logic        err_sum;
  logic        pending;
  logic        start_wr;
  logic        init_wr;
  logic [15:0] main_word;

  assign data_wr = host_wr_i & ~host_port_sel_i;
  assign sel_wr = host_wr_i & host_port_sel_i;
  assign main_wr = data_wr & (sel_ff == ncb_pkg::SEL_MAIN);
  // Auxiliary writes are dropped unless the block is stopped
  assign aux_wr = data_wr & (sel_ff != ncb_pkg::SEL_MAIN)
                  & stop_ff;
  assign stop_req = main_wr & host_wdata_i[ncb_pkg::BIT_STOP];
  // Stop behaves like a power-on reset for flags, timers and control state; select and pointers are kept
  assign clear_all = rst_i | stop_req;
  // Stop beats start and initialize written alongside it
  assign start_wr = main_wr & host_wdata_i[ncb_pkg::BIT_START]
                    & ~stop_req;
  assign init_wr = main_wr & host_wdata_i[ncb_pkg::BIT_INIT]
                   & ~stop_req;

  // Collision pin crosses in from the transceiver
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      col_meta_ff <= 1'b0;
      col_sync_ff <= 1'b0;
    end
    else
    begin
      col_meta_ff <= collision_i;
      col_sync_ff <= col_meta_ff;
    end
  end

  // Event timers: byte count, heartbeat window and DMA ready timeout
  always_comb
  begin
    nxt_byte_cnt = byte_cnt_ff;
    babble_hit = 1'b0;
    if (evt_i.tx_begin)
      nxt_byte_cnt = '0;
    else if (evt_i.tx_byte && byte_cnt_ff != ncb_pkg::BABBLE_BYTES)
    begin
      nxt_byte_cnt = 11'(byte_cnt_ff + 11'h001);
      // Flag once, transmission itself carries on to its end
      babble_hit = (nxt_byte_cnt == ncb_pkg::BABBLE_BYTES);
    end
    nxt_hb_wait = hb_wait_ff;
    nxt_hb_cnt = hb_cnt_ff;
    hb_miss = 1'b0;
    if (evt_i.tx_end)
    begin
      nxt_hb_wait = 1'b1;
      nxt_hb_cnt = '0;
    end
    else if (hb_wait_ff)
    begin
      if (col_sync_ff)
        nxt_hb_wait = 1'b0;
      else if (hb_cnt_ff == ncb_pkg::HB_LAST)
      begin
        nxt_hb_wait = 1'b0;
        hb_miss = 1'b1;
      end
      else
        nxt_hb_cnt = 8'(hb_cnt_ff + 8'h01);
    end
    nxt_dma_cnt = '0;
    dma_timeout = 1'b0;
    // Counter holds at its end so the timeout stays asserted every cycle while the cycle is stuck
    if (evt_i.dma_busy && !evt_i.dma_ready)
    begin
      if (dma_cnt_ff == ncb_pkg::DMA_LAST)
      begin
        nxt_dma_cnt = dma_cnt_ff;
        dma_timeout = 1'b1;
      end
      else
        nxt_dma_cnt = 12'(dma_cnt_ff + 12'h001);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (clear_all)
    begin
      byte_cnt_ff <= '0;
      hb_wait_ff <= 1'b0;
      hb_cnt_ff <= '0;
      dma_cnt_ff <= '0;
    end
    else
    begin
      byte_cnt_ff <= nxt_byte_cnt;
      hb_wait_ff <= nxt_hb_wait;
      hb_cnt_ff <= nxt_hb_cnt;
      dma_cnt_ff <= nxt_dma_cnt;
    end
  end

  // Sticky flag sources and write-one clears
  always_comb
  begin
    flag_set = '0;
    flag_set[ncb_pkg::FI_BABBLE] = babble_hit;
    flag_set[ncb_pkg::FI_HEARTBEAT] = hb_miss;
    flag_set[ncb_pkg::FI_MISSED] = evt_i.rx_missed
                                   & ~mode_i.internal_loopback;
    flag_set[ncb_pkg::FI_MEMERR] = dma_timeout;
    flag_set[ncb_pkg::FI_RECEIVE] = evt_i.rx_desc_done
                                    | evt_i.rx_fail;
    flag_set[ncb_pkg::FI_TRANSMIT] = evt_i.tx_desc_done
                                     | evt_i.tx_fail;
    flag_set[ncb_pkg::FI_INITDONE] = evt_i.init_complete & init_ff;
    flag_clr = {host_wdata_i[ncb_pkg::BIT_INITDONE],
                host_wdata_i[ncb_pkg::BIT_TRANSMIT],
                host_wdata_i[ncb_pkg::BIT_RECEIVE],
                host_wdata_i[ncb_pkg::BIT_MEMERR],
                host_wdata_i[ncb_pkg::BIT_MISSED],
                host_wdata_i[ncb_pkg::BIT_HEARTBEAT],
                host_wdata_i[ncb_pkg::BIT_BABBLE]}
               & {ncb_pkg::FLAG_COUNT{main_wr}};
  end

  // One cell per event flag
  genvar gi;
  generate
    for (gi = 0; gi < ncb_pkg::FLAG_COUNT; gi++)
    begin : g_flag
      ncb_flag_cell u_flag
      (
        .clk_i  (clk_i),
        .rst_i  (clear_all),
        .set_i  (flag_set[gi]),
        .clr_i  (flag_clr[gi]),
        .flag_o (flags[gi])
      );
    end
  endgenerate

  // Summary bits are pure functions of the flags, so writes cannot touch them
  assign err_sum = flags[ncb_pkg::FI_BABBLE] | flags[ncb_pkg::FI_HEARTBEAT]
                   | flags[ncb_pkg::FI_MISSED]
                   | flags[ncb_pkg::FI_MEMERR];
  assign pending = flags[ncb_pkg::FI_BABBLE] | flags[ncb_pkg::FI_MISSED]
                   | flags[ncb_pkg::FI_MEMERR] | flags[ncb_pkg::FI_RECEIVE]
                   | flags[ncb_pkg::FI_TRANSMIT]
                   | flags[ncb_pkg::FI_INITDONE];

  // Main control state
  always_comb
  begin
    nxt_stop = stop_ff;
    nxt_start = start_ff | start_wr;
    nxt_init = init_ff | init_wr;
    if (start_wr || init_wr)
      nxt_stop = 1'b0;
    nxt_interrupt_enable = main_wr ? host_wdata_i[ncb_pkg::BIT_INT_ENABLE]
                       : interrupt_enable_ff;
    nxt_inited = inited_ff | flag_set[ncb_pkg::FI_INITDONE];
    nxt_receiver_on = receiver_on_ff;
    nxt_transmitter_on = transmitter_on_ff;
    // On once both init has completed and start is set, in either order
    if (nxt_inited && nxt_start)
    begin
      nxt_receiver_on = receiver_on_ff | ((start_wr | ~inited_ff)
                            & ~mode_i.receiver_disable);
      nxt_transmitter_on = transmitter_on_ff | ((start_wr | ~inited_ff)
                            & ~mode_i.transmitter_disable);
    end
    if (dma_timeout)
    begin
      nxt_receiver_on = 1'b0;
      nxt_transmitter_on = 1'b0;
    end
    if (evt_i.tx_desc_error)
      nxt_transmitter_on = 1'b0;
    // Demand set wins over the core's acknowledge in the same cycle
    nxt_transmit_demand = (main_wr & host_wdata_i[ncb_pkg::BIT_TX_DEMAND])
               | (transmit_demand_ff & ~evt_i.demand_seen);
  end

  always_ff @(posedge clk_i)
  begin
    if (clear_all)
    begin
      stop_ff <= 1'b1;
      start_ff <= 1'b0;
      init_ff <= 1'b0;
      interrupt_enable_ff <= 1'b0;
      receiver_on_ff <= 1'b0;
      transmitter_on_ff <= 1'b0;
      transmit_demand_ff <= 1'b0;
      inited_ff <= 1'b0;
    end
    else
    begin
      stop_ff <= nxt_stop;
      start_ff <= nxt_start;
      init_ff <= nxt_init;
      interrupt_enable_ff <= nxt_interrupt_enable;
      receiver_on_ff <= nxt_receiver_on;
      transmitter_on_ff <= nxt_transmitter_on;
      transmit_demand_ff <= nxt_transmit_demand;
      inited_ff <= nxt_inited;
    end
  end

  // Select port and auxiliary registers
  always_comb
  begin
    nxt_sel = sel_wr ? host_wdata_i[1:0] : sel_ff;
    nxt_addr_low = addr_low_ff;
    nxt_addr_high = addr_high_ff;
    nxt_cfg = cfg_ff;
    if (aux_wr && sel_ff == ncb_pkg::SEL_ADDR_LOW)
      nxt_addr_low = host_wdata_i;
    if (aux_wr && sel_ff == ncb_pkg::SEL_ADDR_HIGH)
      nxt_addr_high = host_wdata_i[7:0];
    if (aux_wr && sel_ff == ncb_pkg::SEL_CONFIG)
      nxt_cfg = host_wdata_i[2:0];
    if (stop_req)
      nxt_cfg = '0;
  end

  // Pointer contents are kept over stop; only power-on touches the select
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel_ff <= ncb_pkg::SEL_RESET;
      addr_low_ff <= '0;
      addr_high_ff <= '0;
      cfg_ff <= '0;
    end
    else
    begin
      sel_ff <= nxt_sel;
      addr_low_ff <= nxt_addr_low;
      addr_high_ff <= nxt_addr_high;
      cfg_ff <= nxt_cfg;
    end
  end

  // Read path: registered, a read never alters any bit
  always_comb
  begin
    main_word = {err_sum, flags[ncb_pkg::FI_BABBLE],
                 flags[ncb_pkg::FI_HEARTBEAT], flags[ncb_pkg::FI_MISSED],
                 flags[ncb_pkg::FI_MEMERR], flags[ncb_pkg::FI_RECEIVE],
                 flags[ncb_pkg::FI_TRANSMIT], flags[ncb_pkg::FI_INITDONE],
                 pending, interrupt_enable_ff, receiver_on_ff, transmitter_on_ff, transmit_demand_ff, stop_ff,
                 start_ff, init_ff};
    nxt_rdata = rdata_ff;
    if (host_rd_i && host_port_sel_i)
      nxt_rdata = {14'h0000, sel_ff};
    else if (host_rd_i && sel_ff == ncb_pkg::SEL_MAIN)
      nxt_rdata = main_word;
    else if (host_rd_i && !stop_ff)
      nxt_rdata = 16'h0000;
    else if (host_rd_i)
    begin
      unique case (sel_ff)
        ncb_pkg::SEL_ADDR_LOW:  nxt_rdata = addr_low_ff;
        ncb_pkg::SEL_ADDR_HIGH: nxt_rdata = {8'h00, addr_high_ff};
        ncb_pkg::SEL_CONFIG:    nxt_rdata = {13'h0000, cfg_ff};
        ncb_pkg::SEL_MAIN:      nxt_rdata = main_word;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_ff <= '0;
    else
      rdata_ff <= nxt_rdata;
  end

  assign host_rdata_o = rdata_ff;
  // Level request; a new edge needs pending cleared or enable toggled
  assign irq_o = pending & interrupt_enable_ff;

  // Control outputs to the controller core
  always_comb
  begin
    ctrl_o.stop = stop_ff;
    ctrl_o.start_operation = start_ff;
    ctrl_o.init_req = init_ff;
    ctrl_o.receiver_on = receiver_on_ff;
    ctrl_o.transmitter_on = transmitter_on_ff;
    ctrl_o.transmit_demand = transmit_demand_ff;
    ctrl_o.init_block_pointer = {addr_high_ff, addr_low_ff};
    ctrl_o.byte_swap = cfg_ff[ncb_pkg::BIT_BYTE_SWAP];
    ctrl_o.strobe_polarity = cfg_ff[ncb_pkg::BIT_STROBE_POL];
    ctrl_o.byte_mask_config = cfg_ff[ncb_pkg::BIT_BYTE_MASK];
  end

endmodule

// ===== sim/ncb_host_model.sv
// Host processor model driving the register select and data ports
`timescale 1ns/1ns
module ncb_host_model
(
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  output logic             port_sel_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic [15:0]      wdata_o
);
  // Idle bus starts quiet; data is inverted after each cycle so a stale
  // value on the data lines can never pass for a fresh one
  initial
  begin
    port_sel_o = 1'b0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 16'hA5A5;
  end

  // One strobe, changed at the falling edge, held across one rising edge
  task automatic cyc(input logic sel, input logic wr, input logic [15:0] d);
  begin
    @(negedge clk_i);
    port_sel_o = sel;
    wr_o = wr;
    rd_o = !wr;
    wdata_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = ~d;
  end
  endtask

  // Select a register; upper select bits written as zeros
  task automatic wr_sel(input logic [1:0] s);
  begin
    cyc(1'b1, 1'b1, {14'h0000, s});
  end
  endtask

  // Write through the data window
  task automatic wr_dat(input logic [15:0] d);
  begin
    cyc(1'b0, 1'b1, d);
  end
  endtask

  // Read through the data window; data is registered one cycle after strobe
  task automatic rd_dat(output logic [15:0] q);
  begin
    cyc(1'b0, 1'b0, 16'h0000);
    q = rdata_i;
  end
  endtask
endmodule

// ===== sim/ncb_csr_checker.sv
// Concurrent checks on the register bank ports
`timescale 1ns/1ns
module ncb_csr_checker
(
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               host_port_sel_i,
  input wire logic               host_wr_i,
  input wire logic               host_rd_i,
  input wire logic [15:0]        host_wdata_i,
  input wire logic [15:0]        host_rdata_o,
  input wire ncb_pkg::ncb_evt_t  evt_i,
  input wire ncb_pkg::ncb_mode_t mode_i,
  input wire ncb_pkg::ncb_ctrl_t ctrl_o,
  input wire logic               irq_o
);
  logic [1:0]  sel_ff;
  logic [1:0]  nxt_sel;
  logic [11:0] stall_ff;
  logic [11:0] nxt_stall;
  logic        mwr;

  // Shadow of the select port and a count of unanswered DMA cycles
  assign mwr = host_wr_i && !host_port_sel_i && sel_ff == 2'h0;
  always_comb
  begin
    nxt_sel = sel_ff;
    if (host_wr_i && host_port_sel_i)
      nxt_sel = host_wdata_i[1:0];
    nxt_stall = 12'h000;
    if (evt_i.dma_busy && !evt_i.dma_ready && stall_ff != 12'hFFF)
      nxt_stall = stall_ff + 12'h001;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel_ff <= 2'h0;
      stall_ff <= 12'h000;
    end
    else
    begin
      sel_ff <= nxt_sel;
      stall_ff <= nxt_stall;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_main_rd;
    host_rd_i && !host_port_sel_i && sel_ff == 2'h0;
  endsequence
  sequence s_go_wr;
    mwr && !host_wdata_i[2] && (host_wdata_i[1] || host_wdata_i[0]);
  endsequence

  a_stop_quiet: assert property (ctrl_o.stop |-> !irq_o
    && !ctrl_o.start_operation && !ctrl_o.init_req && !ctrl_o.receiver_on
    && !ctrl_o.transmitter_on && !ctrl_o.transmit_demand)
    else $error("outputs active while stopped");
  a_stop_wins: assert property (mwr && host_wdata_i[2] |=> ctrl_o.stop
    && !ctrl_o.start_operation && !ctrl_o.init_req)
    else $error("stop write did not win");
  a_go_unstops: assert property (s_go_wr |=> !ctrl_o.stop
    && (ctrl_o.start_operation || ctrl_o.init_req))
    else $error("start or init did not clear stop");
  a_read_state: assert property (s_main_rd |=> host_rdata_o[5:0] ==
    $past({ctrl_o.receiver_on, ctrl_o.transmitter_on,
    ctrl_o.transmit_demand, ctrl_o.stop, ctrl_o.start_operation,
    ctrl_o.init_req}))
    else $error("main read disagrees with control state");
  a_summary_or: assert property (s_main_rd |=>
    host_rdata_o[15] == (|host_rdata_o[14:11]) && host_rdata_o[7] ==
    (|{host_rdata_o[14], host_rdata_o[12:8]}))
    else $error("summary bits wrong");
  a_irq_level: assert property (s_main_rd |=>
    (host_rdata_o[7] && host_rdata_o[6]) == $past(irq_o))
    else $error("interrupt request not pending and enable");
  a_aux_locked: assert property (host_wr_i && !host_port_sel_i
    && sel_ff != 2'h0 && !ctrl_o.stop |=> $stable(ctrl_o.init_block_pointer)
    && $stable(ctrl_o.byte_swap) && $stable(ctrl_o.byte_mask_config))
    else $error("aux write taken while running");
  a_ptr_load: assert property (host_wr_i && !host_port_sel_i
    && sel_ff == 2'h1 && ctrl_o.stop |=>
    ctrl_o.init_block_pointer[15:0] == $past(host_wdata_i))
    else $error("pointer low word not loaded");
  a_dma_timeout: assert property (stall_ff == 12'hA00 |-> ##[0:2]
    !ctrl_o.receiver_on && !ctrl_o.transmitter_on)
    else $error("receiver or transmitter on after memory timeout");
  a_txerr_off: assert property (evt_i.tx_desc_error |=>
    !ctrl_o.transmitter_on)
    else $error("transmitter on after descriptor error");
  a_rx_gate: assert property ($rose(ctrl_o.receiver_on) |->
    !mode_i.receiver_disable)
    else $error("receiver on although disabled");
  a_demand_ack: assert property (evt_i.demand_seen
    && !(mwr && host_wdata_i[3]) |=> !ctrl_o.transmit_demand)
    else $error("transmit demand not cleared");
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the network controller register bank
`timescale 1ns/1ns
bind ncb_csr_bank ncb_csr_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .host_port_sel_i(host_port_sel_i), .host_wr_i(host_wr_i),
  .host_rd_i(host_rd_i), .host_wdata_i(host_wdata_i),
  .host_rdata_o(host_rdata_o), .evt_i(evt_i), .mode_i(mode_i),
  .ctrl_o(ctrl_o), .irq_o(irq_o));
module testbench;
  logic               clk;
  logic               rst;
  logic               psel;
  logic               wr;
  logic               rd;
  logic [15:0]        wdata;
  logic [15:0]        rdata;
  ncb_pkg::ncb_evt_t  evt;
  ncb_pkg::ncb_mode_t mode;
  logic               col;
  ncb_pkg::ncb_ctrl_t ctrl;
  logic               irq;
  int                 mismatches;
  int                 n_tests;
  int                 cycles;
  // Event masks: missed, rx done, rx fail, tx done, tx fail, with their bits
  logic [12:0] em [5] = '{13'h0200, 13'h0100, 13'h0080, 13'h0040, 13'h0020};
  logic [15:0] eb [5] = '{16'h1000, 16'h0400, 16'h0400, 16'h0200, 16'h0200};

  ncb_csr_bank DUT (.clk_i(clk), .rst_i(rst), .host_port_sel_i(psel),
    .host_wr_i(wr), .host_rd_i(rd), .host_wdata_i(wdata),
    .host_rdata_o(rdata), .evt_i(evt), .mode_i(mode), .collision_i(col),
    .ctrl_o(ctrl), .irq_o(irq));
  ncb_host_model host (.clk_i(clk), .rdata_i(rdata), .port_sel_o(psel),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

  // Clock and hang guard; the run needs well under 20000 cycles
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
  begin
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
  begin
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask

  // Read the selected register and compare the masked bits
  task automatic rdm(input logic [15:0] m, input logic [15:0] e);
    logic [15:0] q;
  begin
    host.rd_dat(q);
    chk(q & m, e);
  end
  endtask

  // Hold an event pattern for n rising edges, then drop it
  task automatic pulse(input logic [12:0] m, input int n);
  begin
    @(negedge clk);
    evt = ncb_pkg::ncb_evt_t'(m);
    repeat (n) @(negedge clk);
    evt = ncb_pkg::ncb_evt_t'(13'h0000);
  end
  endtask

  // Host bring-up: stop, reload aux registers, init, pulse init done, start
  task automatic bring_up(input logic [2:0] md);
  begin
    host.wr_sel(2'h0);
    host.wr_dat(16'h0004);
    host.wr_sel(2'h1);
    host.wr_dat(16'h1234);
    host.wr_sel(2'h2);
    host.wr_dat(16'h0056);
    host.wr_sel(2'h3);
    host.wr_dat(16'h0000);
    host.wr_sel(2'h0);
    mode = ncb_pkg::ncb_mode_t'(md);
    host.wr_dat(16'h0001);
    pulse(13'h0008, 1);
    host.wr_dat(16'h0042);
  end
  endtask

  task automatic s_reset();
  begin
    rdm(16'hFFFF, 16'h0004);
    chk(16'(irq), 16'h0000);
    host.wr_sel(2'h3);
    rdm(16'hFFFF, 16'h0000);
    host.wr_dat(16'h0007);
    rdm(16'hFFFF, 16'h0007);
    rdm(16'hFFFF, 16'h0007);
    host.wr_sel(2'h0);
    host.wr_dat(16'h0004);
    chk(16'({ctrl.byte_swap, ctrl.strobe_polarity, ctrl.byte_mask_config}),
      16'h0000);
  end
  endtask

  task automatic s_run();
  begin
    bring_up(3'h0);
    rdm(16'hFFFF, 16'h01F3);
    chk(16'(irq), 16'h0001);
    chk(ctrl.init_block_pointer[23:8], 16'h5612);
    host.wr_sel(2'h1);
    host.wr_dat(16'hFFFE);
    chk(ctrl.init_block_pointer[15:0], 16'h1234);
    host.wr_sel(2'h0);
    host.wr_dat(16'h0140);
    rdm(16'hFFFF, 16'h0073);
    chk(16'(irq), 16'h0000);
  end
  endtask

  task automatic s_flags();
  begin
    for (int i = 0; i < 5; i++)
    begin
      pulse(em[i], 1);
      rdm(16'hFF80, eb[i] | 16'h0080 |
        ((eb[i] == 16'h1000) ? 16'h8000 : 16'h0000));
      chk(16'(irq), 16'h0001);
      host.wr_dat(16'h0040);
      rdm(eb[i], eb[i]);
      host.wr_dat(eb[i] | 16'h0040);
      rdm(16'hFF80, 16'h0000);
    end
    mode = ncb_pkg::ncb_mode_t'(3'h1);
    pulse(13'h0200, 1);
    rdm(16'h1000, 16'h0000);
    mode = ncb_pkg::ncb_mode_t'(3'h0);
  end
  endtask

  task automatic s_babble();
  begin
    pulse(13'h0800, 1);
    pulse(13'h1000, 1518);
    rdm(16'h4000, 16'h0000);
    pulse(13'h1000, 1);
    rdm(16'hC080, 16'hC080);
    host.wr_dat(16'h4040);
  end
  endtask

  task automatic s_heart();
  begin
    pulse(13'h0400, 1);
    repeat (50) @(negedge clk);
    col = 1'b1;
    repeat (5) @(negedge clk);
    col = 1'b0;
    repeat (250) @(negedge clk);
    rdm(16'h2000, 16'h0000);
    pulse(13'h0400, 1);
    repeat (190) @(negedge clk);
    rdm(16'h2000, 16'h0000);
    repeat (15) @(negedge clk);
    rdm(16'hA080, 16'hA000);
    host.wr_dat(16'h2040);
  end
  endtask

  task automatic s_txerr();
  begin
    pulse(13'h0010, 1);
    chk(16'({ctrl.receiver_on, ctrl.transmitter_on}), 16'h0002);
    host.wr_dat(16'h0048);
    chk(16'(ctrl.transmit_demand), 16'h0001);
    pulse(13'h0004, 1);
    chk(16'(ctrl.transmit_demand), 16'h0000);
  end
  endtask

  task automatic s_memerr();
  begin
    pulse(13'h0003, 2600);
    pulse(13'h0002, 2000);
    rdm(16'h0820, 16'h0020);
    pulse(13'h0002, 2600);
    rdm(16'h8830, 16'h8800);
    host.wr_dat(16'h0007);
    rdm(16'hFFFF, 16'h0004);
    chk(16'(irq), 16'h0000);
  end
  endtask

  task automatic s_disable();
  begin
    bring_up(3'h4);
    rdm(16'h0030, 16'h0010);
    bring_up(3'h2);
    rdm(16'h0030, 16'h0020);
  end
  endtask

  // Main sequence: reset for three cycles, then each scenario in turn
  initial
  begin
    mismatches = 0;
    n_tests = 0;
    rst = 1'b1;
    evt = ncb_pkg::ncb_evt_t'(13'h0000);
    mode = ncb_pkg::ncb_mode_t'(3'h0);
    col = 1'b0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    s_reset();
    s_run();
    s_flags();
    s_babble();
    s_heart();
    s_txerr();
    s_memerr();
    s_disable();
    conclude();
  end
endmodule
